// [rtl/cs_trim_regs.vh]
// register indices, field positions, reset values and range table of the secondary sense trim block
`ifndef CS_TRIM_REGS_VH
`define CS_TRIM_REGS_VH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define IDX_GAIN_TRIM 6'h23
`define IDX_OFFSET_TRIM 6'h24
`define IDX_DIGITAL_TRIM 6'h25
`define IDX_OC_LIMIT 6'h26
`define IDX_STATUS 6'h28
`define IDX_MASK 6'h29
`define IDX_VALUE 6'h2A

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define GAIN_RANGE_HI 7
`define GAIN_RANGE_LO 6
`define GAIN_SIGN_BIT 5
`define GAIN_TRIM_HI 4
`define OFFS_TOPOLOGY_BIT 7
`define OFFS_SIGN_BIT 6
`define OFFS_TRIM_HI 5
`define ST_OVERCURRENT_BIT 0
`define ST_BAD_RANGE_BIT 1
`define ST_WIDTH 2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_GAIN_TRIM 8'h00
`define RST_OFFSET_TRIM 8'h00
`define RST_DIGITAL_TRIM 8'h00
`define RST_OC_LIMIT 8'hFE
`define RST_MASK 2'h0

// ------------------------------------------------------------
// range codes and their full scale (uV) and step (10 nV units)
// ------------------------------------------------------------
`define RANGE_LOW 2'h0
`define RANGE_MID 2'h1
`define RANGE_HIGH 2'h2
`define RANGE_RESERVED 2'h3
`define FS_LOW_UV 18'h0927C
`define FS_MID_UV 18'h124F8
`define FS_HIGH_UV 18'h249F0
`define LSB_LOW_10NV 13'h05F6
`define LSB_MID_10NV 13'h0BEC
`define LSB_HIGH_10NV 13'h17D8

`endif

// [rtl/secondary_current_sense.v]
// secondary current sense trim registers, APB slave, overcurrent compare and interrupt
`timescale 1ns/1ps
`include "cs_trim_regs.vh"

module secondary_current_sense #(
    // byte address and sample widths
    parameter ADDR_WIDTH = 8,
    parameter VALUE_WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    // register bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // converter samples
    input wire [VALUE_WIDTH-1:0] raw_value,
    input wire raw_valid,
    // analog trim controls
    output reg [1:0] secondary_range_select,
    output reg [17:0] full_scale_uv,
    output reg [12:0] lsb_step_10nv,
    output wire [4:0] secondary_gain_adjust,
    output wire gain_negative,
    output wire secondary_topology_select,
    output wire offset_negative,
    output wire [5:0] secondary_offset_adjust,
    // value, limit flag, interrupt
    output wire [VALUE_WIDTH-1:0] secondary_current_value,
    output reg secondary_overcurrent_threshold,
    output wire irq
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // one byte per word;
    // upper bits read zero
    reg [7:0] secondary_gain_trim_q; // range, sign, gain trim
    reg [7:0] secondary_offset_analog_trim_q; // topology, sign, offset trim
    reg [7:0] secondary_digital_trim_q; // signed value correction
    reg [7:0] secondary_overcurrent_limit_q; // compare threshold
    // bit 0 overcurrent, bit 1 bad range
    reg [`ST_WIDTH-1:0] status_q; // sticky events
    reg [`ST_WIDTH-1:0] mask_q; // interrupt enables
    reg [`ST_WIDTH-1:0] status_snap_q; // status bits seen by a read in flight
    // decode results
    reg [7:0] rd_byte; // selected register byte
    reg hit; // address decodes to a register
    reg writable; // register accepts writes

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire [5:0] idx; // word index from byte address
    wire aligned; // low address bits are zero
    wire setup_ph; // first cycle of a transfer
    wire access_ph; // completing cycle
    wire wr_ok; // write takes effect this edge
    wire rd_done; // read completes this edge
    wire [1:0] wr_range; // range code in write data
    // sample path
    wire [VALUE_WIDTH-1:0] corrected; // trimmed current value
    wire corrected_valid; // strobe with corrected
    wire over; // present value above limit
    reg [`ST_WIDTH-1:0] set_ev; // events this cycle

    // stray byte lanes are refused, not folded
    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    // zero wait states: every access finishes in its first access cycle
    // no register here needs a stall
    assign pready = 1'b1;
    // flagged in access only; refused writes do nothing
    assign pslverr = access_ph && (!hit || (pwrite && !writable));
    assign wr_ok = access_ph && pwrite && hit && writable;
    assign rd_done = access_ph && !pwrite && hit;
    assign wr_range = pwdata[`GAIN_RANGE_HI:`GAIN_RANGE_LO];

    // defaults first so no latch forms
    // map index to read byte and access class
    always @* begin
        rd_byte = 8'h00;
        hit = aligned;
        writable = 1'b1;
        case (idx)
            `IDX_GAIN_TRIM: begin
                rd_byte = secondary_gain_trim_q;
            end
            `IDX_OFFSET_TRIM: begin
                rd_byte = secondary_offset_analog_trim_q;
            end
            `IDX_DIGITAL_TRIM: begin
                rd_byte = secondary_digital_trim_q;
            end
            `IDX_OC_LIMIT: begin
                rd_byte = secondary_overcurrent_limit_q;
            end
            `IDX_STATUS: begin
                rd_byte = {6'h00, status_q};
                writable = 1'b0; // cleared by reading only
            end
            `IDX_MASK: begin
                rd_byte = {6'h00, mask_q};
            end
            `IDX_VALUE: begin
                rd_byte = corrected;
                writable = 1'b0;
            end
            default: begin
                hit = 1'b0; // unmapped reads zero, errors
            end
        endcase
    end

    // ------------------------------------------------------------
    // read data, captured in setup so prdata comes from a flop
    // ------------------------------------------------------------
    // loaded a cycle early, off the decode path;
    // cost: returns the value seen in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            status_snap_q <= {`ST_WIDTH{1'b0}};
        end else if (setup_ph) begin
            prdata <= {24'h000000, rd_byte};
            // remember what this read returns so only those bits clear
            if (!pwrite && hit && idx == `IDX_STATUS) begin
                status_snap_q <= status_q;
            end else begin
                status_snap_q <= {`ST_WIDTH{1'b0}};
            end
        end
    end

    // ------------------------------------------------------------
    // trim and limit registers
    // ------------------------------------------------------------
    // writes land at the access edge only;
    // refused writes never reach here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_gain_trim_q <= `RST_GAIN_TRIM;
            secondary_offset_analog_trim_q <= `RST_OFFSET_TRIM;
            secondary_digital_trim_q <= `RST_DIGITAL_TRIM;
            secondary_overcurrent_limit_q <= `RST_OC_LIMIT;
            mask_q <= `RST_MASK;
        end else if (wr_ok) begin
            case (idx)
                `IDX_GAIN_TRIM: begin
                    // reserved code keeps the old range, sign and trim still load
                    if (wr_range == `RANGE_RESERVED) begin
                        secondary_gain_trim_q <= {secondary_gain_trim_q[7:6],
                                                  pwdata[5:0]};
                    end else begin
                        secondary_gain_trim_q <= pwdata[7:0];
                    end
                end
                `IDX_OFFSET_TRIM: begin
                    secondary_offset_analog_trim_q <= pwdata[7:0];
                end
                `IDX_DIGITAL_TRIM: begin
                    secondary_digital_trim_q <= pwdata[7:0];
                end
                `IDX_OC_LIMIT: begin
                    // 255 is not clamped: software is trusted to stay at 254 or below
                    secondary_overcurrent_limit_q <= pwdata[7:0];
                end
                `IDX_MASK: begin
                    // bits above the status width drop
                    mask_q <= pwdata[`ST_WIDTH-1:0];
                end
                default: begin
                    mask_q <= mask_q; // read-only targets never reach here
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog control fields
    // ------------------------------------------------------------
    // bits drive the trim network directly
    // write takes effect at the access edge
    // trim order is left to software
    assign secondary_gain_adjust = secondary_gain_trim_q[`GAIN_TRIM_HI:0];
    assign gain_negative = secondary_gain_trim_q[`GAIN_SIGN_BIT];
    assign secondary_topology_select = secondary_offset_analog_trim_q[`OFFS_TOPOLOGY_BIT];
    assign offset_negative = secondary_offset_analog_trim_q[`OFFS_SIGN_BIT];
    assign secondary_offset_adjust = secondary_offset_analog_trim_q[`OFFS_TRIM_HI:0];

    // range decode registered; reserved code never stored so default serves only the low range
    // range, scale and step change together
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_range_select <= `RANGE_LOW;
            full_scale_uv <= `FS_LOW_UV;
            lsb_step_10nv <= `LSB_LOW_10NV;
        end else begin
            secondary_range_select <= secondary_gain_trim_q[`GAIN_RANGE_HI:`GAIN_RANGE_LO];
            // low range also takes the default
            case (secondary_gain_trim_q[`GAIN_RANGE_HI:`GAIN_RANGE_LO])
                `RANGE_MID: begin
                    full_scale_uv <= `FS_MID_UV;
                    lsb_step_10nv <= `LSB_MID_10NV;
                end
                `RANGE_HIGH: begin
                    full_scale_uv <= `FS_HIGH_UV;
                    lsb_step_10nv <= `LSB_HIGH_10NV;
                end
                default: begin
                    full_scale_uv <= `FS_LOW_UV;
                    lsb_step_10nv <= `LSB_LOW_10NV;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // digital trim and overcurrent compare
    // ------------------------------------------------------------
    // one cycle of latency in the trim stage;
    // the compare uses what software reads
    value_correction #(
        .WIDTH(VALUE_WIDTH)
    ) value_correction_inst (
        .pclk(pclk),
        .presetn(presetn),
        .raw_value(raw_value),
        .raw_valid(raw_valid),
        .trim(secondary_digital_trim_q),
        .corrected_q(corrected),
        .corrected_valid_q(corrected_valid)
    );

    // software and compare see one value
    assign secondary_current_value = corrected;
    // strict greater-than: equal to the limit is still safe
    // a limit of 255 could never trip
    assign over = (corrected > secondary_overcurrent_limit_q);

    // flag follows each new sample and a changed limit
    // level, drops when value falls back
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_overcurrent_threshold <= 1'b0;
        end else begin
            secondary_overcurrent_threshold <= over;
        end
    end

    // ------------------------------------------------------------
    // sticky status and interrupt
    // ------------------------------------------------------------
    // events pulse for one cycle;
    // status holds them until read
    // this cycle's events
    always @* begin
        set_ev = {`ST_WIDTH{1'b0}};
        set_ev[`ST_OVERCURRENT_BIT] = corrected_valid && over;
        set_ev[`ST_BAD_RANGE_BIT] = wr_ok && (idx == `IDX_GAIN_TRIM) &&
                                    (wr_range == `RANGE_RESERVED);
    end

    // a new event in the clearing cycle survives: set wins over clear
    // only returned bits clear, so an event
    // between setup and access survives
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= {`ST_WIDTH{1'b0}};
        end else if (rd_done && idx == `IDX_STATUS) begin
            // status read: clear what was returned
            status_q <= (status_q & ~status_snap_q) | set_ev;
        end else begin
            // no read: events only accumulate
            status_q <= status_q | set_ev;
        end
    end

    // level interrupt from registers;
    // masking hides a bit, status keeps it
    assign irq = |(status_q & mask_q);

endmodule // secondary_current_sense

// [rtl/value_correction.v]
// digital trim stage: adds a signed trim to the raw secondary current sample, saturating
`timescale 1ns/1ps

module value_correction #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] raw_value, // unsigned sample from the converter
    input wire raw_valid, // one-cycle strobe with raw_value
    input wire [WIDTH-1:0] trim, // two's complement correction
    output reg [WIDTH-1:0] corrected_q, // trimmed sample
    output reg corrected_valid_q // one-cycle strobe with corrected_q
);

    // ------------------------------------------------------------
    // signed sum, one bit wider than both operands plus sign
    // ------------------------------------------------------------
    wire signed [WIDTH+1:0] sum;
    reg [WIDTH-1:0] corrected_d;

    assign sum = $signed({2'b00, raw_value}) + $signed({trim[WIDTH-1], trim[WIDTH-1], trim});

    // saturate so a large trim never wraps a full-scale reading to zero
    always @* begin
        if (sum[WIDTH+1]) begin
            corrected_d = {WIDTH{1'b0}}; // below zero
        end else if (sum[WIDTH]) begin
            corrected_d = {WIDTH{1'b1}}; // above full scale
        end else begin
            corrected_d = sum[WIDTH-1:0];
        end
    end

    // register the result so the compare downstream sees a clean value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corrected_q <= {WIDTH{1'b0}};
            corrected_valid_q <= 1'b0;
        end else begin
            corrected_valid_q <= raw_valid;
            if (raw_valid) begin
                corrected_q <= corrected_d;
            end
        end
    end

endmodule // value_correction

// [tb/secondary_current_sense_monitor.sv]
// concurrent checks on the ports of the secondary current sense block
`timescale 1ns/1ps
`include "cs_trim_regs.vh"

module secondary_current_sense_monitor #(
    parameter ADDR_WIDTH = 8,
    parameter VALUE_WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [VALUE_WIDTH-1:0] raw_value,
    input wire raw_valid,
    input wire [1:0] secondary_range_select,
    input wire [17:0] full_scale_uv,
    input wire [12:0] lsb_step_10nv,
    input wire [4:0] secondary_gain_adjust,
    input wire gain_negative,
    input wire secondary_topology_select,
    input wire offset_negative,
    input wire [5:0] secondary_offset_adjust,
    input wire [VALUE_WIDTH-1:0] secondary_current_value,
    input wire secondary_overcurrent_threshold
);
    // ------------------------------------------------------------
    // shadow copies of trim and limit
    // ------------------------------------------------------------
    reg [7:0] trim_q; // trim as last written
    reg [7:0] limit_q; // limit as last written
    wire wr_acc = psel && penable && pwrite; // write lands at this edge
    // shadows follow writes at the access edge, like the block itself
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= `RST_DIGITAL_TRIM;
            limit_q <= `RST_OC_LIMIT;
        end else if (wr_acc && paddr == {`IDX_DIGITAL_TRIM, 2'b00}) begin
            trim_q <= pwdata[7:0];
        end else if (wr_acc && paddr == {`IDX_OC_LIMIT, 2'b00}) begin
            limit_q <= pwdata[7:0];
        end
    end
    // saturating add of a signed trim; bit 9 flags an underflow
    function [7:0] sat(input [7:0] v, input [7:0] t);
        reg [9:0] s;
        begin
            s = {2'b00, v} + {{2{t[7]}}, t};
            sat = s[9] ? 8'h00 : (s[8] ? 8'hFF : s[7:0]);
        end
    endfunction
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence gain_wr;
        wr_acc && paddr == {`IDX_GAIN_TRIM, 2'b00};
    endsequence
    sequence off_wr;
        wr_acc && paddr == {`IDX_OFFSET_TRIM, 2'b00};
    endsequence
    range_fs_a: assert property ($stable(secondary_range_select) |->
        full_scale_uv == (secondary_range_select == 2'h1 ? 18'h124F8 :
        (secondary_range_select == 2'h2 ? 18'h249F0 : 18'h0927C)))
        else $error("full scale does not follow range");
    range_lsb_a: assert property ($stable(secondary_range_select) |->
        lsb_step_10nv == (secondary_range_select == 2'h1 ? 13'h0BEC :
        (secondary_range_select == 2'h2 ? 13'h17D8 : 13'h05F6)))
        else $error("step size does not follow range");
    range_legal_a: assert property (secondary_range_select != 2'h3)
        else $error("reserved range code reached the output");
    range_wr_a: assert property (gain_wr ##0 (pwdata[7:6] != 2'h3) |->
        ##2 secondary_range_select == $past(pwdata[7:6], 2))
        else $error("range write not applied");
    gain_wr_a: assert property (gain_wr |=>
        secondary_gain_adjust == $past(pwdata[4:0]) && gain_negative == $past(pwdata[5]))
        else $error("gain trim write not applied");
    offset_wr_a: assert property (off_wr |=>
        secondary_topology_select == $past(pwdata[7]) && offset_negative == $past(pwdata[6])
        && secondary_offset_adjust == $past(pwdata[5:0]))
        else $error("offset trim write not applied");
    value_trim_a: assert property (raw_valid |=>
        secondary_current_value == sat($past(raw_value), $past(trim_q)))
        else $error("trimmed value wrong");
    over_flag_a: assert property (secondary_overcurrent_threshold ==
        ($past(secondary_current_value) > $past(limit_q)))
        else $error("overcurrent output does not follow compare");
endmodule // secondary_current_sense_monitor

// [tb/secondary_current_sense_tb.sv]
// self-checking bench for the secondary current sense block
`timescale 1ns/1ps
`include "cs_trim_regs.vh"

module secondary_current_sense_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam [7:0] A_GAIN = {`IDX_GAIN_TRIM, 2'b00};
    localparam [7:0] A_OFFS = {`IDX_OFFSET_TRIM, 2'b00};
    localparam [7:0] A_TRIM = {`IDX_DIGITAL_TRIM, 2'b00};
    localparam [7:0] A_LIM = {`IDX_OC_LIMIT, 2'b00};
    localparam [7:0] A_ST = {`IDX_STATUS, 2'b00};
    localparam [7:0] A_MASK = {`IDX_MASK, 2'b00};
    localparam [7:0] A_VAL = {`IDX_VALUE, 2'b00};
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [7:0] raw_value = 8'h00;
    reg raw_valid = 1'b0;
    wire pready, pslverr, gneg, topo, oneg, ovr, irq;
    wire [31:0] prdata;
    wire [1:0] rng;
    wire [17:0] fs;
    wire [12:0] lsb;
    wire [4:0] gadj;
    wire [5:0] oadj;
    wire [7:0] cval;
    integer err_count = 0;
    integer num_checks = 0;
    always #20 pclk = ~pclk; // 25 MHz
    secondary_current_sense secondary_current_sense_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .raw_value(raw_value),
        .raw_valid(raw_valid), .secondary_range_select(rng), .full_scale_uv(fs),
        .lsb_step_10nv(lsb), .secondary_gain_adjust(gadj), .gain_negative(gneg),
        .secondary_topology_select(topo), .offset_negative(oneg),
        .secondary_offset_adjust(oadj), .secondary_current_value(cval),
        .secondary_overcurrent_threshold(ovr), .irq(irq));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // wait states end only by pready or the watchdog
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg [31:0] q;
        reg e;
        begin
            apb(1'b1, a, {24'h0, d}, q, e);
            chk("write response", 32'h0, {31'h0, e});
        end
    endtask
    task rdc(input string name, input [7:0] a, input [31:0] exp);
        reg [31:0] q;
        reg e;
        begin
            apb(1'b0, a, 32'h0, q, e);
            chk(name, exp, q);
        end
    endtask
    // one converter sample; returns once threshold and irq have settled
    task smp(input [7:0] v);
        begin
            @(posedge pclk);
            raw_value <= v;
            raw_valid <= 1'b1;
            @(posedge pclk);
            raw_valid <= 1'b0;
            @(posedge pclk);
            #1;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            rdc("gain reset", A_GAIN, 32'h0);
            rdc("offset reset", A_OFFS, 32'h0);
            rdc("trim reset", A_TRIM, 32'h0);
            rdc("limit reset", A_LIM, 32'hFE);
            chk("fs reset", 32'h927C, {14'h0, fs});
            chk("lsb reset", 32'h5F6, {19'h0, lsb});
        end
    endtask
    // every legal range code, then the reserved one
    task t_range;
        integer i;
        reg [31:0] ef, el;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                wr(A_GAIN, {i[1:0], 6'h31 + i[5:0]});
                repeat (2) @(posedge pclk);
                #1;
                ef = (i == 0) ? 32'h927C : ((i == 1) ? 32'h124F8 : 32'h249F0);
                el = (i == 0) ? 32'h5F6 : ((i == 1) ? 32'hBEC : 32'h17D8);
                chk("range", i, {30'h0, rng});
                chk("full scale", ef, {14'h0, fs});
                chk("lsb step", el, {19'h0, lsb});
                chk("gain adjust", 32'h11 + i, {27'h0, gadj});
                chk("gain sign", 32'h1, {31'h0, gneg});
            end
            wr(A_GAIN, 8'hC4);
            repeat (2) @(posedge pclk);
            #1;
            chk("range kept", 32'h2, {30'h0, rng});
            chk("gain after reserved", 32'h4, {27'h0, gadj});
            rdc("gain readback", A_GAIN, 32'h84);
            rdc("status reserved", A_ST, 32'h2);
        end
    endtask
    task t_offset;
        integer i;
        reg [7:0] v;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                v = i ? 8'h3A : 8'hC5;
                wr(A_OFFS, v);
                chk("topology", v[7], topo);
                chk("offset sign", v[6], oneg);
                chk("offset adjust", v[5:0], oadj);
                rdc("offset readback", A_OFFS, {24'h0, v});
            end
        end
    endtask
    // saturation at both ends; limit still 0xFE so 0xFF exceeds it
    task t_trim;
        begin
            wr(A_TRIM, 8'h05);
            smp(8'hFE);
            chk("value high clamp", 32'hFF, cval);
            chk("above limit", 32'h1, ovr);
            smp(8'h10);
            chk("value plus", 32'h15, cval);
            wr(A_TRIM, 8'hFB);
            smp(8'h03);
            chk("value low clamp", 32'h0, cval);
            smp(8'h10);
            rdc("value readback", A_VAL, 32'h0B);
            rdc("status sticky", A_ST, 32'h1);
        end
    endtask
    task t_ocp;
        begin
            wr(A_LIM, 8'h80);
            wr(A_TRIM, 8'h00);
            wr(A_MASK, 8'h01);
            smp(8'h80);
            chk("equal not over", 32'h0, ovr);
            chk("irq quiet", 32'h0, irq);
            smp(8'h81);
            chk("one above", 32'h1, ovr);
            chk("irq raised", 32'h1, irq);
            rdc("status over", A_ST, 32'h1);
            chk("irq cleared", 32'h0, irq);
            wr(A_MASK, 8'h00);
            smp(8'h90);
            chk("irq masked", 32'h0, irq);
            wr(A_MASK, 8'h01);
            chk("irq unmasked", 32'h1, irq);
            rdc("status clear", A_ST, 32'h1);
        end
    endtask
    // unmapped and read-only places answer with an error and keep state
    task t_err;
        reg [31:0] q;
        reg e;
        begin
            apb(1'b1, 8'h04, 32'h55, q, e);
            chk("unmapped write err", 32'h1, e);
            apb(1'b1, A_VAL, 32'hAA, q, e);
            chk("read-only write err", 32'h1, e);
            apb(1'b0, A_MASK + 8'h01, 32'h0, q, e);
            chk("unaligned read err", 32'h1, e);
            rdc("value untouched", A_VAL, 32'h90);
            rdc("unmapped read", 8'h04, 32'h0);
        end
    endtask
    // ------------------------------------------------------------
    // verdict, main sequence, watchdog
    // ------------------------------------------------------------
    task final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_range;
        t_offset;
        t_trim;
        t_ocp;
        t_err;
        final_report;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        err_count = err_count + 1;
        final_report;
    end
endmodule // secondary_current_sense_tb

bind secondary_current_sense secondary_current_sense_monitor #(.ADDR_WIDTH(ADDR_WIDTH),
    .VALUE_WIDTH(VALUE_WIDTH)) monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .raw_value, .raw_valid, .secondary_range_select, .full_scale_uv,
    .lsb_step_10nv, .secondary_gain_adjust, .gain_negative, .secondary_topology_select,
    .offset_negative, .secondary_offset_adjust, .secondary_current_value,
    .secondary_overcurrent_threshold);
